// *** dpsm_port_ctrl.sv ***
// Contract
// - Take token: write 0, read back 0
// - Token select low needs memory select high
// - Read/write and output enable as memory
// - Write 1 to cancel ownership or request
// - Software frees every token at start
`timescale 1ns/100ps
module dpsm_port_ctrl #(
   parameter int DATA_W       = 9,
   parameter int ADDR_W       = 12,
   parameter int POLL_MAX     = 16,
   parameter bit PORT_IS_LEFT = 1'b1
) (
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire dpsm_pkg::dpsm_op_t cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_wdata,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic                   rsp_granted,
   output logic                   mbox_pending,
   output logic                   ram_select_n,
   output logic                   token_select_n,
   output logic                   read_write_n,
   output logic                   output_enable_n,
   output logic [ADDR_W-1:0]      port_addr,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_oe_n,
   input  wire logic [DATA_W-1:0] data_in,
   input  wire logic              port_mailbox_flag_n
);

   localparam logic [ADDR_W-1:0] MBOX_SEND_ADDR = ADDR_W'(PORT_IS_LEFT ? dpsm_pkg::MBOX_TO_RIGHT
                                                                      : dpsm_pkg::MBOX_TO_LEFT);
   localparam logic [ADDR_W-1:0] MBOX_READ_ADDR = ADDR_W'(PORT_IS_LEFT ? dpsm_pkg::MBOX_TO_LEFT
                                                                      : dpsm_pkg::MBOX_TO_RIGHT);
   localparam logic [7:0] POLL_LAST = 8'(POLL_MAX - 1);
   localparam logic [dpsm_pkg::TOKEN_IDX_W-1:0] IDX_LAST = dpsm_pkg::TOKEN_IDX_W'(dpsm_pkg::TOKEN_COUNT - 1);

   dpsm_pkg::dpsm_state_t state_reg;
   dpsm_pkg::dpsm_state_t state_next;
   dpsm_pkg::dpsm_op_t    op_reg;
   logic [7:0]            cnt_reg;
   logic [7:0]            cnt_next;
   logic [1:0]            phase_reg;
   logic [1:0]            phase_next;
   logic [dpsm_pkg::TOKEN_IDX_W-1:0] idx_reg;
   logic [dpsm_pkg::TOKEN_IDX_W-1:0] idx_next;
   logic [7:0]            polls_reg;
   logic [7:0]            polls_next;
   logic                  step_sem_reg;
   logic                  step_sem_next;
   logic                  step_wr_reg;
   logic                  step_wr_next;
   logic [ADDR_W-1:0]     step_addr_reg;
   logic [ADDR_W-1:0]     step_addr_next;
   logic [DATA_W-1:0]     step_wdata_reg;
   logic [DATA_W-1:0]     step_wdata_next;
   logic [DATA_W-1:0]     rdata_reg;
   logic                  launch;
   logic                  finish;
   logic                  granted;
   logic                  pin_active;

   // Pin input conditioning, flag inverted to active high
   dpsm_sync_if #(.W(DATA_W + 1)) pin_if ();
   assign pin_if.raw = {~port_mailbox_flag_n, data_in};

   dpsm_sync3 #(.W(DATA_W + 1)) u_sync (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .sif     (pin_if)
   );

   // Step planner: first step from command, next step after each recovery
   always_comb begin
      launch          = 1'b0;
      finish          = 1'b0;
      granted         = 1'b0;
      phase_next      = phase_reg;
      idx_next        = idx_reg;
      polls_next      = polls_reg;
      step_sem_next   = step_sem_reg;
      step_wr_next    = step_wr_reg;
      step_addr_next  = step_addr_reg;
      step_wdata_next = step_wdata_reg;
      if (state_reg == dpsm_pkg::ST_IDLE && cmd_valid) begin
         launch          = 1'b1;
         phase_next      = dpsm_pkg::PH_FIRST;
         polls_next      = 8'h00;
         idx_next        = cmd_addr[dpsm_pkg::TOKEN_IDX_W-1:0];
         step_sem_next   = 1'b1;
         step_wr_next    = 1'b1;
         // token index only, upper lines zero
         step_addr_next  = ADDR_W'(cmd_addr[dpsm_pkg::TOKEN_IDX_W-1:0]);
         // token value on data bit 0
         step_wdata_next = DATA_W'(cmd_wdata[0]);
         unique case (cmd_op)
            dpsm_pkg::OP_MEM_READ: begin
               step_sem_next  = 1'b0;
               step_wr_next   = 1'b0;
               step_addr_next = cmd_addr;
            end
            dpsm_pkg::OP_MEM_WRITE: begin
               step_sem_next   = 1'b0;
               step_addr_next  = cmd_addr;
               step_wdata_next = cmd_wdata;
            end
            dpsm_pkg::OP_TOKEN_WRITE: begin
            end
            dpsm_pkg::OP_TOKEN_READ: begin
               step_wr_next = 1'b0;
            end
            dpsm_pkg::OP_TOKEN_TAKE: begin
               step_wdata_next = DATA_W'(dpsm_pkg::TOKEN_TAKE);
            end
            dpsm_pkg::OP_TOKEN_FREE: begin
               step_wdata_next = DATA_W'(dpsm_pkg::TOKEN_FREE);
            end
            // free all tokens from index 0
            dpsm_pkg::OP_TOKEN_INIT: begin
               idx_next        = '0;
               step_addr_next  = '0;
               step_wdata_next = DATA_W'(dpsm_pkg::TOKEN_FREE);
            end
            // mailbox word of the far port
            dpsm_pkg::OP_MBOX_SEND: begin
               step_sem_next   = 1'b0;
               step_addr_next  = MBOX_SEND_ADDR;
               step_wdata_next = cmd_wdata;
            end
            // own mailbox read clears own flag
            dpsm_pkg::OP_MBOX_READ: begin
               step_sem_next  = 1'b0;
               step_wr_next   = 1'b0;
               step_addr_next = MBOX_READ_ADDR;
            end
            default: begin
               launch = 1'b0;
               finish = 1'b1;
            end
         endcase
      end else if (state_reg == dpsm_pkg::ST_DECIDE) begin
         finish = 1'b1;
         if (op_reg == dpsm_pkg::OP_TOKEN_TAKE) begin
            if (phase_reg == dpsm_pkg::PH_FIRST) begin
               finish       = 1'b0;
               launch       = 1'b1;
               phase_next   = dpsm_pkg::PH_POLL;
               step_wr_next = 1'b0;
            end else if (phase_reg == dpsm_pkg::PH_POLL) begin
               // 0 means this port owns it
               if (rdata_reg[0] == dpsm_pkg::TOKEN_TAKE) begin
                  granted = 1'b1;
               end else if (polls_reg == POLL_LAST) begin
                  // give up, cancel the pending request
                  finish          = 1'b0;
                  launch          = 1'b1;
                  phase_next      = dpsm_pkg::PH_CANCEL;
                  step_wr_next    = 1'b1;
                  step_wdata_next = DATA_W'(dpsm_pkg::TOKEN_FREE);
               end else begin
                  finish     = 1'b0;
                  launch     = 1'b1;
                  polls_next = polls_reg + 8'h01;
               end
            end
         end else if (op_reg == dpsm_pkg::OP_TOKEN_INIT && idx_reg != IDX_LAST) begin
            finish         = 1'b0;
            launch         = 1'b1;
            idx_next       = idx_reg + 1'b1;
            step_addr_next = ADDR_W'(idx_reg + 1'b1);
         end
      end
   end

   // Sequencer next state and per-state cycle counter
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         dpsm_pkg::ST_IDLE, dpsm_pkg::ST_DECIDE: begin
            if (launch) begin
               state_next = dpsm_pkg::ST_SETUP;
               cnt_next   = 8'(dpsm_pkg::SETUP_CYC - 1);
            end else begin
               state_next = dpsm_pkg::ST_IDLE;
            end
         end
         dpsm_pkg::ST_SETUP: begin
            if (cnt_reg == 8'h00) begin
               state_next = dpsm_pkg::ST_ACT;
               cnt_next   = step_wr_reg ? 8'(dpsm_pkg::STROBE_CYC - 1) : 8'(dpsm_pkg::READ_CYC - 1);
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         dpsm_pkg::ST_ACT: begin
            if (cnt_reg == 8'h00) begin
               state_next = dpsm_pkg::ST_HOLD;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         dpsm_pkg::ST_HOLD: begin
            state_next = dpsm_pkg::ST_RECOVER;
            cnt_next   = 8'(dpsm_pkg::RECOVER_CYC - 1);
         end
         dpsm_pkg::ST_RECOVER: begin
            if (cnt_reg == 8'h00) begin
               state_next = dpsm_pkg::ST_DECIDE;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
      endcase
   end

   // State, counter and step registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg      <= dpsm_pkg::ST_IDLE;
         cnt_reg        <= 8'h00;
         op_reg         <= dpsm_pkg::OP_MEM_READ;
         phase_reg      <= dpsm_pkg::PH_FIRST;
         idx_reg        <= '0;
         polls_reg      <= 8'h00;
         step_sem_reg   <= 1'b0;
         step_wr_reg    <= 1'b0;
         step_addr_reg  <= '0;
         step_wdata_reg <= '0;
      end else begin
         state_reg      <= state_next;
         cnt_reg        <= cnt_next;
         phase_reg      <= phase_next;
         idx_reg        <= idx_next;
         polls_reg      <= polls_next;
         step_sem_reg   <= step_sem_next;
         step_wr_reg    <= step_wr_next;
         step_addr_reg  <= step_addr_next;
         step_wdata_reg <= step_wdata_next;
         if (state_reg == dpsm_pkg::ST_IDLE && cmd_valid) begin
            op_reg <= cmd_op;
         end
      end
   end

   // Read capture at the end of the strobe
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= '0;
      end else if (state_reg == dpsm_pkg::ST_ACT && cnt_reg == 8'h00 && !step_wr_reg) begin
         rdata_reg <= pin_if.clean[DATA_W-1:0];
      end
   end

   // Answer and mailbox status
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rsp_valid    <= 1'b0;
         rsp_rdata    <= '0;
         rsp_granted  <= 1'b0;
         mbox_pending <= 1'b0;
      end else begin
         rsp_valid    <= finish;
         mbox_pending <= pin_if.clean[DATA_W];
         if (finish) begin
            rsp_rdata   <= rdata_reg;
            rsp_granted <= granted;
         end
      end
   end

   assign pin_active = (state_reg == dpsm_pkg::ST_SETUP) || (state_reg == dpsm_pkg::ST_ACT)
                       || (state_reg == dpsm_pkg::ST_HOLD);

   // Registered pin drive, one cycle behind the sequencer
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ram_select_n    <= 1'b1;
         token_select_n  <= 1'b1;
         read_write_n    <= 1'b1;
         output_enable_n <= 1'b1;
         port_addr       <= '0;
         data_out        <= '0;
         data_oe_n       <= 1'b1;
      end else begin
         // never both selects low; both high when idle
         ram_select_n    <= !(pin_active && !step_sem_reg);
         token_select_n  <= !(pin_active && step_sem_reg);
         read_write_n    <= !(state_reg == dpsm_pkg::ST_ACT && step_wr_reg);
         // read with output enable low; high otherwise
         output_enable_n <= !(state_reg == dpsm_pkg::ST_ACT && !step_wr_reg);
         port_addr       <= step_addr_reg;
         data_out        <= step_wdata_reg;
         data_oe_n       <= !(step_wr_reg && ((state_reg == dpsm_pkg::ST_ACT)
                                              || (state_reg == dpsm_pkg::ST_HOLD)));
      end
   end

   assign cmd_ready = (state_reg == dpsm_pkg::ST_IDLE);

endmodule

// *** dpsm_pkg.sv ***
package dpsm_pkg;

   // Clock and pin timing, times in ns
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_SETUP_NS    = 10;   // Address and select ahead of strobe
   localparam int T_STROBE_NS   = 40;   // Write strobe width
   localparam int T_ACCESS_NS   = 55;   // Output valid after read strobe
   localparam int T_RECOVER_NS  = 15;   // token_read_recovery_gap, selects high

   // Least times round up, never below one cycle
   localparam int SETUP_CYC   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC  = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_CYC  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Input path latency: three flops, agreement stage, one pin register lag
   localparam int SYNC_LAT_CYC = 5;
   localparam int READ_CYC     = ACCESS_CYC + SYNC_LAT_CYC;

   // Token array and mailbox words
   localparam int          TOKEN_COUNT   = 8;
   localparam int          TOKEN_IDX_W   = 3;
   localparam logic [11:0] MBOX_TO_RIGHT = 12'hFFF;   // Left writes, right reads
   localparam logic [11:0] MBOX_TO_LEFT  = 12'hFFE;   // Right writes, left reads

   // Token values
   localparam logic TOKEN_TAKE = 1'h0;
   localparam logic TOKEN_FREE = 1'h1;

   // Host commands
   typedef enum logic [3:0] {
      OP_MEM_READ    = 4'h0,
      OP_MEM_WRITE   = 4'h1,
      OP_TOKEN_WRITE = 4'h2,
      OP_TOKEN_READ  = 4'h3,
      OP_TOKEN_TAKE  = 4'h4,
      OP_TOKEN_FREE  = 4'h5,
      OP_TOKEN_INIT  = 4'h6,
      OP_MBOX_SEND   = 4'h7,
      OP_MBOX_READ   = 4'h8
   } dpsm_op_t;

   // Pin sequencer states
   typedef enum logic [5:0] {
      ST_IDLE    = 6'h01,
      ST_SETUP   = 6'h02,
      ST_ACT     = 6'h04,
      ST_HOLD    = 6'h08,
      ST_RECOVER = 6'h10,
      ST_DECIDE  = 6'h20
   } dpsm_state_t;

   // Phases of a multi-step token command
   localparam logic [1:0] PH_FIRST  = 2'h0;
   localparam logic [1:0] PH_POLL   = 2'h1;
   localparam logic [1:0] PH_CANCEL = 2'h2;

endpackage

// *** dpsm_sync_if.sv ***
`timescale 1ns/100ps
interface dpsm_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// *** dpsm_sync3.sv ***
`timescale 1ns/100ps
module dpsm_sync3 #(
   parameter int W = 1
) (
   input wire logic  clk_sys,
   input wire logic  arst_n,
   dpsm_sync_if.sync sif
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] clean_reg;

   // Three-flop chain; first stage feeds only the second
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= sif.raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Bit changes only once stages two and three agree
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         clean_reg <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               clean_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   assign sif.clean = clean_reg;

endmodule

// *** dpsm_port_ctrl_chk.sv ***
`timescale 1ns/100ps
module dpsm_port_ctrl_chk #(
   parameter int DATA_W = 9,
   parameter int ADDR_W = 12
) (
   input wire logic               clk_sys,
   input wire logic               arst_n,
   input wire logic               cmd_valid,
   input wire logic               cmd_ready,
   input wire dpsm_pkg::dpsm_op_t cmd_op,
   input wire logic               rsp_valid,
   input wire logic               mbox_pending,
   input wire logic               ram_select_n,
   input wire logic               token_select_n,
   input wire logic               read_write_n,
   input wire logic               output_enable_n,
   input wire logic [ADDR_W-1:0]  port_addr,
   input wire logic [DATA_W-1:0]  data_out,
   input wire logic               data_oe_n,
   input wire logic               port_mailbox_flag_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   a_sel_excl: assert property (!(!ram_select_n && !token_select_n))
      else $error("both selects low");
   a_oe_rw_excl: assert property (!(!output_enable_n && !read_write_n))
      else $error("read and write strobes together");
   a_oe_floats: assert property (!output_enable_n |-> data_oe_n)
      else $error("controller drives during device read");
   a_tok_addr: assert property (!token_select_n |-> port_addr[ADDR_W-1:3] == '0)
      else $error("token address high bits set");
   a_tok_wdata: assert property ((!token_select_n && !data_oe_n) |-> data_out[DATA_W-1:1] == '0)
      else $error("token write data above bit 0");
   a_gap_idle: assert property (($rose(ram_select_n) || $rose(token_select_n))
      |=> ram_select_n && token_select_n) else $error("select released without idle gap");
   a_write_answer: assert property ((cmd_valid && cmd_ready && cmd_op == dpsm_pkg::OP_MEM_WRITE)
      |=> !rsp_valid [*6] ##1 rsp_valid) else $error("write answer not at 7 cycles");
   a_read_answer: assert property ((cmd_valid && cmd_ready && cmd_op == dpsm_pkg::OP_MEM_READ)
      |-> ##13 rsp_valid) else $error("read answer not at 13 cycles");
   a_ready_drop: assert property ((cmd_valid && cmd_ready && cmd_op <= dpsm_pkg::OP_MBOX_READ)
      |=> !cmd_ready) else $error("ready stays high after take");
   a_mbox_follow: assert property (!port_mailbox_flag_n [*8] |-> mbox_pending)
      else $error("mailbox flag not followed");
   a_bad_op: assert property ((cmd_valid && cmd_ready && cmd_op > dpsm_pkg::OP_MBOX_READ)
      |=> rsp_valid && cmd_ready && ram_select_n && token_select_n)
      else $error("unknown command not answered at once");
   a_wr_drives: assert property (!read_write_n |-> !data_oe_n)
      else $error("write strobe without data drive");
endmodule

bind dpsm_port_ctrl dpsm_port_ctrl_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (
   .clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .cmd_op(cmd_op), .rsp_valid(rsp_valid), .mbox_pending(mbox_pending),
   .ram_select_n(ram_select_n), .token_select_n(token_select_n), .read_write_n(read_write_n),
   .output_enable_n(output_enable_n), .port_addr(port_addr), .data_out(data_out),
   .data_oe_n(data_oe_n), .port_mailbox_flag_n(port_mailbox_flag_n));

// *** dpsm_dev_model.sv ***
`timescale 1ns/100ps
module dpsm_dev_model (
   input  wire logic        ram_select_n,
   input  wire logic        token_select_n,
   input  wire logic        read_write_n,
   input  wire logic        output_enable_n,
   input  wire logic [11:0] port_addr,
   input  wire logic [8:0]  data_out,
   output logic [8:0]       data_in,
   output logic             port_mailbox_flag_n
);
   logic [1:0] owner [8];
   logic       req   [2][8];
   logic [8:0] mem   [4096];
   logic [8:0] rd_val;
   logic       flag_r_n;
   logic       drv;

   // eight latches, no free state at power-up
   initial begin
      foreach (owner[i]) owner[i] = 2'h1;
      foreach (req[p, i]) req[p][i] = 1'b0;
      rd_val = 9'h000;
      flag_r_n = 1'b1;
      port_mailbox_flag_n = 1'b1;
   end

   function automatic logic view(input int p, input int i);
      return (owner[i] == 2'(p + 1)) ? 1'b0 : 1'b1;
   endfunction

   task automatic tok_write(input int p, input int i, input logic b);
      int o;
      o = 1 - p;
      if (!b) begin
         if (owner[i] == 2'h0) owner[i] = 2'(p + 1);
         else if (owner[i] != 2'(p + 1)) req[p][i] = 1'b1;
      end else begin
         req[p][i] = 1'b0;
         if (owner[i] == 2'(p + 1)) begin
            owner[i] = req[o][i] ? 2'(o + 1) : 2'h0;
            req[o][i] = 1'b0;
         end
      end
   endtask

   // far port writes its mailbox word
   task automatic right_mem_write(input logic [11:0] a, input logic [8:0] d);
      mem[a] = d;
      if (a == 12'hFFE) port_mailbox_flag_n = 1'b0;
   endtask

   // writes commit as the strobe rises
   always @(posedge read_write_n) begin
      if (!token_select_n && ram_select_n) tok_write(0, int'(port_addr[2:0]), data_out[0]);
      else if (!ram_select_n && token_select_n) begin
         mem[port_addr] = data_out;
         if (port_addr == 12'hFFF) flag_r_n = 1'b0;
      end
   end

   // read value latched when output enable falls
   always @(negedge output_enable_n) begin
      if (!token_select_n && ram_select_n) rd_val = {9{view(0, int'(port_addr[2:0]))}};
      else if (!ram_select_n && token_select_n) begin
         rd_val = mem[port_addr];
         if (port_addr == 12'hFFE) port_mailbox_flag_n = 1'b1;
      end
   end

   // released bus shows the inverse of the last value
   assign drv = !output_enable_n && read_write_n && (ram_select_n != token_select_n);
   assign data_in = drv ? rd_val : ~rd_val;
endmodule

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
   typedef struct {
      int                 ract;
      dpsm_pkg::dpsm_op_t op;
      logic [11:0]        addr;
      logic [8:0]         wd;
      bit                 chk;
      logic [8:0]         rd;
      logic               g;
      logic               rv;
   } dpsm_row_t;

   logic               clk_sys, arst_n, cmd_valid, cmd_ready, rsp_valid, rsp_granted, mbox_pending;
   logic               ram_select_n, token_select_n, read_write_n, output_enable_n, data_oe_n;
   logic               port_mailbox_flag_n;
   dpsm_pkg::dpsm_op_t cmd_op;
   logic [11:0]        cmd_addr, port_addr;
   logic [8:0]         cmd_wdata, rsp_rdata, data_out, data_in;
   int                 n_fail, num_checks;
   dpsm_row_t          rows [10] = '{
      '{0, dpsm_pkg::OP_TOKEN_READ,  12'h002, 9'h000, 1, 9'h1FF, 0, 1},
      '{0, dpsm_pkg::OP_TOKEN_TAKE,  12'h005, 9'h000, 1, 9'h000, 1, 1},
      '{1, dpsm_pkg::OP_TOKEN_READ,  12'h005, 9'h000, 1, 9'h000, 0, 1},
      '{0, dpsm_pkg::OP_TOKEN_WRITE, 12'h005, 9'h001, 0, 9'h000, 0, 0},
      '{0, dpsm_pkg::OP_TOKEN_READ,  12'h005, 9'h000, 1, 9'h1FF, 0, 0},
      '{0, dpsm_pkg::OP_TOKEN_TAKE,  12'h005, 9'h000, 1, 9'h1FF, 0, 0},
      '{2, dpsm_pkg::OP_TOKEN_READ,  12'h005, 9'h000, 1, 9'h1FF, 0, 1},
      '{0, dpsm_pkg::OP_TOKEN_WRITE, 12'hFF5, 9'h1FE, 0, 9'h000, 0, 1},
      '{0, dpsm_pkg::OP_TOKEN_READ,  12'h005, 9'h000, 1, 9'h000, 0, 1},
      '{0, dpsm_pkg::OP_TOKEN_FREE,  12'h005, 9'h000, 0, 9'h000, 0, 1}};

   dpsm_port_ctrl #(.POLL_MAX(2)) dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_granted(rsp_granted), .mbox_pending(mbox_pending),
      .ram_select_n(ram_select_n), .token_select_n(token_select_n), .read_write_n(read_write_n),
      .output_enable_n(output_enable_n), .port_addr(port_addr), .data_out(data_out),
      .data_oe_n(data_oe_n), .data_in(data_in), .port_mailbox_flag_n(port_mailbox_flag_n));

   dpsm_dev_model dev (
      .ram_select_n(ram_select_n), .token_select_n(token_select_n), .read_write_n(read_write_n),
      .output_enable_n(output_enable_n), .port_addr(port_addr), .data_out(data_out),
      .data_in(data_in), .port_mailbox_flag_n(port_mailbox_flag_n));

   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // One command, held until taken, then wait for the answer
   task automatic do_cmd(input dpsm_pkg::dpsm_op_t op, input logic [11:0] a, input logic [8:0] wd);
      int k;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= wd;
      k = 0;
      do begin @(negedge clk_sys); k++; end while (cmd_ready !== 1'b1 && k < 200);
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      k = 0;
      do begin @(negedge clk_sys); k++; end while (rsp_valid !== 1'b1 && k < 400);
      if (k >= 400) check(9'h000, 9'h001);
   endtask

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      finish_test;
   end

   initial begin
      arst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = dpsm_pkg::OP_MEM_READ;
      cmd_addr = 12'h000;
      cmd_wdata = 9'h000;
      n_fail = 0;
      num_checks = 0;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      for (int i = 0; i < 8; i++) dev.tok_write(1, i, 1'b1);
      do_cmd(dpsm_pkg::OP_TOKEN_INIT, 12'h000, 9'h000);
      // Table of token sequences, far port acting first
      foreach (rows[i]) begin
         if (rows[i].ract != 0) dev.tok_write(1, int'(rows[i].addr[2:0]), rows[i].ract == 2);
         do_cmd(rows[i].op, rows[i].addr, rows[i].wd);
         if (rows[i].chk) begin
            check(rsp_rdata, rows[i].rd);
            check({8'h00, rsp_granted}, {8'h00, rows[i].g});
         end
         check({8'h00, dev.view(1, int'(rows[i].addr[2:0]))}, {8'h00, rows[i].rv});
         $display("row %0d done", i);
      end
      do_cmd(dpsm_pkg::OP_MEM_WRITE, 12'h123, 9'h15A);
      do_cmd(dpsm_pkg::OP_MEM_READ, 12'h123, 9'h000);
      check(rsp_rdata, 9'h15A);
      dev.right_mem_write(12'hFFE, 9'h0A5);
      repeat (10) @(posedge clk_sys);
      check({8'h00, mbox_pending}, 9'h001);
      do_cmd(dpsm_pkg::OP_MBOX_READ, 12'hFFE, 9'h000);
      check(rsp_rdata, 9'h0A5);
      repeat (10) @(posedge clk_sys);
      check({8'h00, mbox_pending}, 9'h000);
      do_cmd(dpsm_pkg::OP_MBOX_SEND, 12'hFFF, 9'h03C);
      check({8'h00, dev.flag_r_n}, 9'h000);
      $display("mailbox test done");
      // Far port requests while the take is in flight
      fork
         do_cmd(dpsm_pkg::OP_TOKEN_TAKE, 12'h003, 9'h000);
         begin repeat (4) @(posedge clk_sys); dev.tok_write(1, 3, 1'b0); end
      join
      check({8'h00, rsp_granted}, {8'h00, dev.view(1, 3)});
      do_cmd(dpsm_pkg::dpsm_op_t'(4'hF), 12'h000, 9'h000);
      check({8'h00, rsp_granted}, 9'h000);
      $display("contention test done");
      // Reset in mid-read
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_op <= dpsm_pkg::OP_MEM_READ;
      cmd_addr <= 12'h123;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b0;
      @(negedge clk_sys);
      check({5'h00, ram_select_n, token_select_n, output_enable_n, rsp_valid}, 9'h00E);
      @(posedge clk_sys);
      arst_n <= 1'b1;
      do_cmd(dpsm_pkg::OP_MEM_READ, 12'h123, 9'h000);
      check(rsp_rdata, 9'h15A);
      $display("reset test done");
      finish_test;
   end
endmodule
